// *** common/pin_mux_params.svh ***
// Register offsets, field positions and reset values of the pin function block
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH

`define OFS_PIN_SELECT    8'h00
`define OFS_CLOCK_CONFIG  8'h04
`define OFS_CONTROL       8'h08
`define OFS_IO_BASE       8'h0C
`define OFS_DMA           8'h10
`define OFS_STATUS        8'h14

`define RST_PIN_SELECT    8'h00
`define RST_CLOCK_CONFIG  8'h00
`define RST_CONTROL       8'h00
`define RST_IO_BASE       16'h0000

`define FLD_PIN2_LO       0
`define FLD_PIN3_LO       2
`define FLD_PIN0_LO       4
`define FLD_PIN1_LO       6
`define FLD_CLK_24M       5
`define FLD_IRQ8_HIGH     0
`define FLD_EPP_MODE      1
`define FLD_DMA_DONE_LO   4

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// *** common/pin_mux_pkg.sv ***
// Types shared by the pin function block
package pin_mux_pkg;
  typedef enum logic [2:0] {
    REG_PIN_SELECT   = 3'b000,
    REG_CLOCK_CONFIG = 3'b001,
    REG_CONTROL      = 3'b010,
    REG_IO_BASE      = 3'b011,
    REG_DMA          = 3'b100,
    REG_STATUS       = 3'b101,
    REG_NONE         = 3'b111
  } reg_e;

  typedef enum logic [1:0] {
    FN_HOST  = 2'b00,
    FN_GPIO  = 2'b01,
    FN_ALT   = 2'b10,
    FN_UART3 = 2'b11
  } pin_fn_e;

  typedef struct packed {
    logic o;
    logic oe_n;
  } pin_drive_s;
endpackage : pin_mux_pkg

// *** core/sync_2ff.sv ***
// Two-flop synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps
module sync_2ff #(
  parameter int             WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : sync_2ff

// *** core/host_pin_function_mux.sv ***
// Shared host pin routing, DMA handshakes, EPP ready extension and AXI4-Lite registers
`timescale 1ns/1ps
`include "pin_mux_params.svh"

// Operation
// - Select bits 5:4 route shared pin 0 to DMA 0 acknowledge, GPIO1 bit 6, keyboard bit 5 or UART3 RTS.
// - Select bits 7:6 route shared pin 1 to DMA 0 request, GPIO1 bit 7, keyboard bit 4 or UART3 DTR.
// - Select bits 1:0 route shared pin 2 to IRQ 14, GPIO1 bit 4, power LED or IR module select 1.
// - Select bits 3:2 route shared pin 3 to IRQ 15, GPIO1 bit 5, watchdog or IR module select 2.
// - After reset every select field is 00 so the pins carry the host DMA 0 and IRQ 14/15 functions.
// - Code 11 only takes effect on the variant with the third UART; otherwise the pin floats.
// - The master reset input is active high and resets the block's logic while high.
// - In EPP mode the open-drain channel ready output is pulled low until the cycle can complete.
// - Terminal count sampled during an acknowledged cycle ends that channel's DMA transfer.
// - Each of the four channels raises its request and the host answers with its acknowledge.
// - Interrupt 8 is active low by default for the clock interrupt, active high on selection.
// - A clock configuration bit tells whether a 14.318 MHz or 24 MHz reference is present.
// - Host I/O accesses are decoded on all 16 address bits.
module host_pin_function_mux
  import pin_mux_pkg::*;
#(
  parameter int       ADDR_W    = 8,
  parameter bit       HAS_UART3 = 1'b1
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    master_reset_in,
  input  wire logic [15:0]             host_addr,
  input  wire logic                    host_ior_n,
  input  wire logic                    host_iow_n,
  input  wire logic                    host_aen,
  input  wire logic                    epp_cycle_done,
  output logic                         iochrdy_o,
  output logic                         iochrdy_oe_n,
  input  wire logic [3:1]              dma_ack_n,
  input  wire logic                    dma_tc,
  output logic [3:1]                   dma_req,
  output logic [3:0]                   dma_ack_active,
  input  wire logic [3:0]              shared_pin_i,
  output pin_mux_pkg::pin_drive_s [3:0] shared_pin_drv,
  output logic [3:0]                   shared_pin_in,
  input  wire pin_mux_pkg::pin_drive_s [7:4] gpio1_drv,
  input  wire pin_mux_pkg::pin_drive_s [5:4] kbc_port1_drv,
  input  wire logic                    uart3_request_to_send,
  input  wire logic                    uart3_terminal_ready,
  input  wire logic                    ir_module_sel_1,
  input  wire logic                    ir_module_sel_2,
  input  wire logic                    power_led_out,
  input  wire logic                    watchdog_out,
  input  wire logic                    irq14_src,
  input  wire logic                    irq15_src,
  input  wire logic                    rtc_irq_event,
  output logic                         rtc_irq_active_low,
  output logic                         ref_clock_24m_sel
);
  import pin_mux_pkg::*;
  localparam int SYNC_W = 28;

  logic [SYNC_W-1:0] sync_q;
  logic [15:0]       addr_s;
  logic              ior_n_s, iow_n_s, aen_s, tc_s, mr_s;
  logic [3:1]        dack_n_s;
  logic [3:0]        pin_s;
  logic              rst;

  // Strobes and acknowledges idle high; resetting them high avoids a false cycle
  sync_2ff #(
    .WIDTH     (SYNC_W),
    .RESET_VAL ({16'h0000, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3'h7, 4'hF})
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({host_addr, host_ior_n, host_iow_n, host_aen, dma_tc, master_reset_in, dma_ack_n, shared_pin_i}),
    .sync_out (sync_q)
  );

  assign {addr_s, ior_n_s, iow_n_s, aen_s, tc_s, mr_s, dack_n_s, pin_s} = sync_q;
  assign rst = !aresetn || mr_s;

  function automatic reg_e decode(input logic [ADDR_W-1:0] a);
    case (a[7:0])
      `OFS_PIN_SELECT:   decode = REG_PIN_SELECT;
      `OFS_CLOCK_CONFIG: decode = REG_CLOCK_CONFIG;
      `OFS_CONTROL:      decode = REG_CONTROL;
      `OFS_IO_BASE:      decode = REG_IO_BASE;
      `OFS_DMA:          decode = REG_DMA;
      `OFS_STATUS:       decode = REG_STATUS;
      default:           decode = REG_NONE;
    endcase
  endfunction : decode

  function automatic pin_drive_s route(input logic [1:0] sel, input pin_drive_s f0, input pin_drive_s f1,
                                       input pin_drive_s f2, input pin_drive_s f3);
    case (pin_fn_e'(sel))
      FN_HOST:  route = f0;
      FN_GPIO:  route = f1;
      FN_ALT:   route = f2;
      FN_UART3: route = HAS_UART3 ? f3 : pin_drive_s'{o: 1'b1, oe_n: 1'b1};
      default:  route = '{o: 1'b1, oe_n: 1'b1};
    endcase
  endfunction : route

  // Register bus
  logic [7:0]        pin_sel_q;
  logic [7:0]        clk_cfg_q;
  logic [7:0]        ctrl_q;
  logic [15:0]       io_base_q;
  logic [3:0]        dma_req_q, dma_done_q;
  logic              aw_have_q, w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              wr_fire;
  reg_e              wr_reg;
  logic              ext_q;
  logic [3:0]        dack_s;
  logic [3:0]        tc_end;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_reg        = decode(aw_addr_q);

  always_ff @(posedge aclk) begin
    if (rst) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_addr_q    <= '0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_reg == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      pin_sel_q <= `RST_PIN_SELECT;
      clk_cfg_q <= `RST_CLOCK_CONFIG;
      ctrl_q    <= `RST_CONTROL;
      io_base_q <= `RST_IO_BASE;
    end else if (wr_fire) begin
      case (wr_reg)
        REG_PIN_SELECT:   if (w_strb_q[0]) pin_sel_q <= w_data_q[7:0];
        REG_CLOCK_CONFIG: if (w_strb_q[0]) clk_cfg_q <= w_data_q[7:0];
        REG_CONTROL:      if (w_strb_q[0]) ctrl_q <= w_data_q[7:0];
        REG_IO_BASE: begin
          if (w_strb_q[0]) io_base_q[7:0] <= w_data_q[7:0];
          if (w_strb_q[1]) io_base_q[15:8] <= w_data_q[15:8];
        end
        default: ;
      endcase
    end
  end

  // DMA: software raises a request, terminal count under acknowledge ends it
  assign dack_s = {~dack_n_s, (pin_sel_q[5:4] == FN_HOST) ? ~pin_s[0] : 1'b0};
  assign tc_end = (tc_s ? dack_s : 4'h0) & dma_req_q;

  always_ff @(posedge aclk) begin
    if (rst) begin
      dma_req_q  <= 4'h0;
      dma_done_q <= 4'h0;
    end else begin
      if (wr_fire && wr_reg == REG_DMA && w_strb_q[0]) begin
        dma_req_q  <= w_data_q[3:0];
        dma_done_q <= (dma_done_q & ~w_data_q[7:4]) | tc_end; // Set beats clear
      end else begin
        dma_req_q  <= dma_req_q & ~tc_end;
        dma_done_q <= dma_done_q | tc_end;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      dma_req        <= 3'h0;
      dma_ack_active <= 4'h0;
    end else begin
      dma_req        <= dma_req_q[3:1] & ~tc_end[3:1];
      dma_ack_active <= dack_s;
    end
  end

  // Host I/O: all address bits compared, strobes masked during DMA cycles
  logic io_hit;
  assign io_hit = !aen_s && (!ior_n_s || !iow_n_s) && (addr_s == io_base_q);

  always_ff @(posedge aclk) begin
    if (rst) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ctrl_q[`FLD_EPP_MODE] && io_hit && !epp_cycle_done;
    end
  end

  assign iochrdy_o    = 1'b0;
  assign iochrdy_oe_n = !ext_q;

  // Shared pins
  always_ff @(posedge aclk) begin
    if (rst) begin
      shared_pin_drv <= {4{pin_drive_s'{o: 1'b1, oe_n: 1'b1}}};
      shared_pin_in  <= 4'h0;
    end else begin
      shared_pin_drv[0] <= route(pin_sel_q[`FLD_PIN0_LO +: 2], '{o: 1'b1, oe_n: 1'b1}, gpio1_drv[6],
                                 kbc_port1_drv[5], '{o: uart3_request_to_send, oe_n: 1'b0});
      shared_pin_drv[1] <= route(pin_sel_q[`FLD_PIN1_LO +: 2], '{o: dma_req_q[0] & ~tc_end[0], oe_n: 1'b0},
                                 gpio1_drv[7], kbc_port1_drv[4],
                                 '{o: uart3_terminal_ready, oe_n: 1'b0});
      shared_pin_drv[2] <= route(pin_sel_q[`FLD_PIN2_LO +: 2], '{o: irq14_src, oe_n: 1'b0}, gpio1_drv[4],
                                 '{o: power_led_out, oe_n: 1'b0}, '{o: ir_module_sel_1, oe_n: 1'b0});
      shared_pin_drv[3] <= route(pin_sel_q[`FLD_PIN3_LO +: 2], '{o: irq15_src, oe_n: 1'b0}, gpio1_drv[5],
                                 '{o: watchdog_out, oe_n: 1'b0}, '{o: ir_module_sel_2, oe_n: 1'b0});
      shared_pin_in     <= pin_s;
    end
  end

  // Interrupt 8 polarity and reference clock selection
  always_ff @(posedge aclk) begin
    if (rst) begin
      rtc_irq_active_low <= 1'b1;
      ref_clock_24m_sel  <= 1'b0;
    end else begin
      rtc_irq_active_low <= ctrl_q[`FLD_IRQ8_HIGH] ? rtc_irq_event : !rtc_irq_event;
      ref_clock_24m_sel  <= clk_cfg_q[`FLD_CLK_24M];
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      case (decode(s_axi_araddr))
        REG_PIN_SELECT:   s_axi_rdata <= {24'h000000, pin_sel_q};
        REG_CLOCK_CONFIG: s_axi_rdata <= {24'h000000, clk_cfg_q};
        REG_CONTROL:      s_axi_rdata <= {24'h000000, ctrl_q};
        REG_IO_BASE:      s_axi_rdata <= {16'h0000, io_base_q};
        REG_DMA:          s_axi_rdata <= {24'h000000, dma_done_q, dma_req_q};
        REG_STATUS:       s_axi_rdata <= {19'h0, ext_q, pin_s, dack_s, 4'h0};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  property p_sel_reset;
    @(posedge aclk) rst |=> pin_sel_q == 8'h00;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("select not cleared by reset");
  property p_mr_reset;
    @(posedge aclk) disable iff (!aresetn) mr_s |=> (pin_sel_q == 8'h00) && (dma_req_q == 4'h0);
  endproperty
  a_mr_reset: assert property (p_mr_reset) else $error("master reset ignored");
  property p_pin0_dack;
    @(posedge aclk) disable iff (rst) pin_sel_q[5:4] == 2'b00 |=> shared_pin_drv[0].oe_n;
  endproperty
  a_pin0_dack: assert property (p_pin0_dack) else $error("dack pin driven");
  property p_pin1_drq;
    @(posedge aclk) disable iff (rst)
      (pin_sel_q[7:6] == 2'b00) && dma_req_q[0] && !tc_end[0] |=> !shared_pin_drv[1].oe_n && shared_pin_drv[1].o;
  endproperty
  a_pin1_drq: assert property (p_pin1_drq) else $error("drq0 not on pin");
  property p_pin2_irq;
    @(posedge aclk) disable iff (rst) pin_sel_q[1:0] == 2'b00 |=> shared_pin_drv[2].o == $past(irq14_src);
  endproperty
  a_pin2_irq: assert property (p_pin2_irq) else $error("irq14 not routed");
  property p_pin3_wdt;
    @(posedge aclk) disable iff (rst) pin_sel_q[3:2] == 2'b10 |=> shared_pin_drv[3].o == $past(watchdog_out);
  endproperty
  a_pin3_wdt: assert property (p_pin3_wdt) else $error("watchdog not routed");
  property p_no_uart3;
    @(posedge aclk) disable iff (rst) !HAS_UART3 && pin_sel_q[7:6] == 2'b11 |=> shared_pin_drv[1].oe_n;
  endproperty
  a_no_uart3: assert property (p_no_uart3) else $error("code 11 active without uart3");
  property p_tc_end;
    @(posedge aclk) disable iff (rst)
      tc_s && !dack_n_s[1] && dma_req_q[1] && !wr_fire |=> !dma_req_q[1] && dma_done_q[1] && !dma_req[1];
  endproperty
  a_tc_end: assert property (p_tc_end) else $error("tc did not end transfer");
  property p_aen_mask;
    @(posedge aclk) disable iff (rst) aen_s |=> iochrdy_oe_n;
  endproperty
  a_aen_mask: assert property (p_aen_mask) else $error("strobe taken during dma");
  property p_epp_ext;
    @(posedge aclk) disable iff (rst)
      ctrl_q[1] && io_hit && !epp_cycle_done |=> !iochrdy_oe_n && !iochrdy_o;
  endproperty
  a_epp_ext: assert property (p_epp_ext) else $error("channel ready not pulled low");
  property p_irq8_pol;
    @(posedge aclk) disable iff (rst) !ctrl_q[0] |=> rtc_irq_active_low == !$past(rtc_irq_event);
  endproperty
  a_irq8_pol: assert property (p_irq8_pol) else $error("irq8 polarity wrong");
endmodule : host_pin_function_mux

// *** testbench/host_dma_model.sv ***
// Behavioural host DMA controller answering the block's request lines
`timescale 1ns/1ps
module host_dma_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] req,
  input  wire logic       tc_on,
  input  wire logic [3:0] delay,
  output logic      [3:0] ack_n,
  output logic            tc
);
  logic [3:0] cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_n <= 4'hF;
      cnt_q <= 4'h0;
    end else if (ack_n == 4'hF) begin
      // Lowest channel wins, after a settable pause
      if (req != 4'h0 && cnt_q >= delay) begin
        ack_n <= ~(req & (~req + 4'h1));
        cnt_q <= 4'h0;
      end else if (req != 4'h0) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end else if ((~ack_n & req) == 4'h0) begin
      ack_n <= 4'hF;
    end
  end

  // Count is only marked inside a granted cycle
  assign tc = tc_on && (ack_n != 4'hF);
endmodule : host_dma_model

// *** testbench/testbench.sv ***
// Self-checking bench for the shared host pin function block
`timescale 1ns/1ps
`include "pin_mux_params.svh"
module testbench;
  import pin_mux_pkg::*;
  logic             aclk = 1'b0;
  logic             aresetn = 1'b0;
  logic [7:0]       s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]      s_axi_wdata = 32'h0, s_axi_rdata;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic             s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  logic             master_reset_in = 1'b0, v = 1'b0, rtc_irq_event = 1'b0, tc_on = 1'b0;
  logic [15:0]      host_addr = 16'h0000;
  logic             host_ior_n = 1'b1, host_iow_n = 1'b1, host_aen = 1'b1, epp_cycle_done = 1'b1;
  logic             iochrdy_o, iochrdy_oe_n, dma_tc, rtc_irq_active_low, ref_clock_24m_sel;
  logic [3:1]       dma_req;
  logic [3:0]       dma_ack_active, shared_pin_i, shared_pin_in, ack_n, drq, delay = 4'h3;
  pin_drive_s [3:0] shared_pin_drv;
  pin_drive_s [7:4] gpio1_drv = '0;
  pin_drive_s [5:4] kbc_port1_drv = '0;
  int               error_cnt = 0, comparisons = 0;

  always #2 aclk = ~aclk;
  assign drq = {dma_req, shared_pin_drv[1].o & !shared_pin_drv[1].oe_n};
  // Released pins 1 to 3 read high through board pull-ups; released pin 0 reads the host's acknowledge 0
  always_comb begin
    shared_pin_i[0] = shared_pin_drv[0].oe_n ? ack_n[0] : shared_pin_drv[0].o;
    for (int i = 1; i < 4; i++) shared_pin_i[i] = shared_pin_drv[i].oe_n ? 1'b1 : shared_pin_drv[i].o;
  end

  host_pin_function_mux uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .master_reset_in, .host_addr, .host_ior_n, .host_iow_n, .host_aen, .epp_cycle_done, .iochrdy_o,
    .iochrdy_oe_n, .dma_ack_n(ack_n[3:1]), .dma_tc, .dma_req, .dma_ack_active, .shared_pin_i,
    .shared_pin_drv, .shared_pin_in, .gpio1_drv, .kbc_port1_drv, .uart3_request_to_send(v),
    .uart3_terminal_ready(v), .ir_module_sel_1(v), .ir_module_sel_2(v), .power_led_out(v),
    .watchdog_out(v), .irq14_src(v), .irq15_src(v), .rtc_irq_event, .rtc_irq_active_low, .ref_clock_24m_sel
  );

  host_dma_model dma_host (.aclk, .aresetn, .req(drq), .tc_on, .delay, .ack_n, .tc(dma_tc));

  task automatic results;
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic hang;
    error_cnt++;
    results();
  endtask : hang

  // Let the edge's register updates land before looking
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : tick

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid & s_axi_awready;
      w_t = s_axi_wvalid & s_axi_wready;
      b_t = s_axi_bvalid & s_axi_bready;
      if (b_t) check({30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) s_axi_bready <= 1'b0;
      if (b_t) return;
    end
    hang();
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_t, r_t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(negedge aclk);
      ar_t = s_axi_arvalid & s_axi_arready;
      r_t = s_axi_rvalid & s_axi_rready;
      if (r_t) check(s_axi_rdata, ed);
      if (r_t) check({30'h0, s_axi_rresp}, {30'h0, er});
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (r_t) s_axi_rready <= 1'b0;
      if (r_t) return;
    end
    hang();
  endtask : axi_read

  task automatic wait_for(input bit dma, input logic val);
    for (int n = 0; n < 64; n++) begin
      @(negedge aclk);
      if (dma ? (drq === 4'h0) : (iochrdy_oe_n === val)) return;
    end
    hang();
  endtask : wait_for

  task automatic reset_values;
    tick(2);
    check(32'(shared_pin_drv & 8'hFD), 32'h01);
    check(ref_clock_24m_sel, 1'b0);
    axi_read(`OFS_PIN_SELECT, 32'h0, `RESP_OKAY);
    axi_read(`OFS_CLOCK_CONFIG, 32'h0, `RESP_OKAY);
  endtask : reset_values

  task automatic pin_table;
    logic [7:0] e;
    logic [1:0] g, s;
    for (int c = 0; c < 4; c++) begin
      axi_write(`OFS_PIN_SELECT, 32'h55 * c, `RESP_OKAY);
      for (int i = 0; i < 2; i++) begin
        @(posedge aclk);
        v <= i[0];
        gpio1_drv <= {4{i[0], !i[0]}};
        kbc_port1_drv <= {2{i[0], !i[0]}};
        tick(3);
        g = {i[0], !i[0]};
        s = {i[0], 1'b0};
        case (c)
          0: e = {s, s, 2'b00, 2'b01};
          1: e = {g, g, g, g};
          2: e = {s, s, g, g};
          default: e = {s, s, s, s};
        endcase
        // Pin 0 is an input under code 00, so its level is masked
        check(32'(shared_pin_drv & ((c == 0) ? 8'hFD : 8'hFF)), e);
      end
    end
  endtask : pin_table

  task automatic master_reset;
    axi_write(`OFS_PIN_SELECT, 32'hFF, `RESP_OKAY);
    @(posedge aclk);
    master_reset_in <= 1'b1;
    tick(4);
    check(32'(shared_pin_drv), 32'hFF);
    @(posedge aclk);
    master_reset_in <= 1'b0;
    tick(4);
    axi_read(`OFS_PIN_SELECT, 32'h0, `RESP_OKAY);
  endtask : master_reset

  task automatic dma_flow;
    axi_write(`OFS_DMA, 32'hF, `RESP_OKAY);
    tick(20);
    check(drq, 4'hF);
    check(dma_ack_active, 4'h1);
    check(shared_pin_in, 4'hE);
    axi_read(`OFS_STATUS, 32'h0000_0E10, `RESP_OKAY);
    @(posedge aclk);
    tc_on <= 1'b1;
    delay <= 4'h0;
    wait_for(1'b1, 1'b0);
    axi_read(`OFS_DMA, 32'hF0, `RESP_OKAY);
    axi_write(`OFS_DMA, 32'hF0, `RESP_OKAY);
    axi_read(`OFS_DMA, 32'h0, `RESP_OKAY);
    tc_on <= 1'b0;
  endtask : dma_flow

  task automatic epp_wait;
    axi_write(`OFS_IO_BASE, 32'h0378, `RESP_OKAY);
    axi_write(`OFS_CONTROL, 32'h2, `RESP_OKAY);
    @(posedge aclk);
    host_addr <= 16'h0378;
    host_ior_n <= 1'b0;
    epp_cycle_done <= 1'b0;
    tick(8);
    check(iochrdy_oe_n, 1'b1);
    @(posedge aclk);
    host_aen <= 1'b0;
    host_addr <= 16'h8378;
    tick(8);
    check(iochrdy_oe_n, 1'b1);
    @(posedge aclk);
    host_addr <= 16'h0378;
    wait_for(1'b0, 1'b0);
    check(iochrdy_o, 1'b0);
    @(posedge aclk);
    epp_cycle_done <= 1'b1;
    wait_for(1'b0, 1'b1);
    @(posedge aclk);
    host_ior_n <= 1'b1;
    host_iow_n <= 1'b0;
    epp_cycle_done <= 1'b0;
    wait_for(1'b0, 1'b0);
    @(posedge aclk);
    host_iow_n <= 1'b1;
    wait_for(1'b0, 1'b1);
  endtask : epp_wait

  task automatic irq8_polarity;
    for (int p = 0; p < 2; p++) begin
      axi_write(`OFS_CONTROL, 32'(p), `RESP_OKAY);
      for (int e = 0; e < 2; e++) begin
        @(posedge aclk);
        rtc_irq_event <= e[0];
        tick(4);
        check(rtc_irq_active_low, p[0] ? e[0] : !e[0]);
      end
    end
  endtask : irq8_polarity

  task automatic clock_and_holes;
    axi_write(`OFS_CLOCK_CONFIG, 32'h20, `RESP_OKAY);
    tick(2);
    check(ref_clock_24m_sel, 1'b1);
    axi_read(`OFS_CLOCK_CONFIG, 32'h20, `RESP_OKAY);
    axi_read(8'h18, 32'h0, `RESP_SLVERR);
    axi_write(8'h1C, 32'hFFFF_FFFF, `RESP_SLVERR);
    axi_read(`OFS_PIN_SELECT, 32'h0, `RESP_OKAY);
  endtask : clock_and_holes

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    reset_values();
    pin_table();
    master_reset();
    dma_flow();
    epp_wait();
    irq8_polarity();
    clock_and_holes();
    results();
  end
endmodule : testbench
